// ==== shared/eii_pkg.sv ====
// Constants, register map and carrier types for the external interrupt input unit.
// Assumes one 100 MHz clock that is also the high-frequency clock of the device.
// Behaviour
// R1: Six external interrupt inputs, each behind its own digital noise filter.
// R2: Shared pin comes out of reset as a port input, not an interrupt.
// R3: Pin-function 0 means port, 1 means interrupt 0; port then stays input.
// R4: With pin-function 0 the interrupt 0 request latch is never set.
// R5: Inputs 0 and 5 fall-edge only; reject under 2, accept 7 fast periods.
// R6: Input 1 window select: 0 rejects under 63, 1 under 15 fast periods.
// R7: Input 1 accepts 49 or 193 fast periods or longer, divider cleared.
// R8: Inputs 2 to 4 reject under 7, accept 25 fast periods, divider cleared.
// R9: In slow modes all filters reject under 1, accept 3.5 slow periods.
// R10: Inputs 1 to 3 have edge select: 0 rising, 1 falling.
// R11: Input 4 select: 00 rise, 01 fall, 10 both, 11 high level.
// R12: Input 4 high after reset gives no request until a rising edge.
// R13: Request needs master and own enable, plus pin-function or level enable.
// R14: Clean edge sets its latch within filter time plus 6 slow periods.
// R15: New input 1 window takes effect within 64 fast periods.
// R16: Software disables interrupts while switching clocks or rewriting control.
// R17: Output-mode pin changes may raise false requests; software clears enables.
// R18: Control register layout bits 7..1, reset zero, bit 0 undefined.
// R19: Filter is synchroniser plus counter restarted on change.
// R20: Qualified trigger sets latch; held until accepted or cleared by software.
package eii_pkg;

  localparam int N_IRQ = 6;

  // Register indices; byte address is four times the index
  localparam int          CTRL_IDX   = 32'h0000_0037;
  localparam int          EN_IDX     = 32'h0000_0038;
  localparam int          LATCH_IDX  = 32'h0000_0039;
  localparam logic [7:0]  ADDR_CTRL  = 8'(CTRL_IDX * 4);
  localparam logic [7:0]  ADDR_EN    = 8'(EN_IDX * 4);
  localparam logic [7:0]  ADDR_LATCH = 8'(LATCH_IDX * 4);

  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [10:0] EN_RST     = 11'h000;
  localparam logic [5:0]  LATCH_RST  = 6'h00;

  typedef enum logic [1:0] {
    TRIG_RISE  = 2'h0,
    TRIG_FALL  = 2'h1,
    TRIG_BOTH  = 2'h2,
    TRIG_LEVEL = 2'h3
  } eii_trig4_e;

  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic       noise_win;
    logic       pin_func;
    eii_trig4_e trig4;
    logic       es3;
    logic       es2;
    logic       es1;
    logic       rsvd;
  } eii_ctrl_s;

  // Enable register: lvl[3:0] for inputs 5..2, ind[5:0] for inputs 5..0
  typedef struct packed {
    logic [3:0] lvl;
    logic [5:0] ind;
    logic       master;
  } eii_en_s;

  // Filter times in fast-clock periods, converted to clk cycles
  localparam int CLK_HZ        = 100_000_000;
  localparam int FC_HZ         = 100_000_000;
  localparam int CLK_PER_FC    = CLK_HZ / FC_HZ;
  localparam int T_INT05_FC    = 2;
  localparam int T_EXT_IRQ_IN1_S_FC   = 15;
  localparam int T_EXT_IRQ_IN1_L_FC   = 63;
  localparam int T_INT234_FC   = 7;
  localparam int SLOW_TICKS    = 2;
  localparam logic [6:0] CNT_INT05  = 7'(T_INT05_FC * CLK_PER_FC);
  localparam logic [6:0] CNT_EXT_IRQ_IN1_S = 7'(T_EXT_IRQ_IN1_S_FC * CLK_PER_FC);
  localparam logic [6:0] CNT_EXT_IRQ_IN1_L = 7'(T_EXT_IRQ_IN1_L_FC * CLK_PER_FC);
  localparam logic [6:0] CNT_INT234 = 7'(T_INT234_FC * CLK_PER_FC);
  localparam logic [6:0] CNT_SLOW   = 7'(SLOW_TICKS);

  localparam logic [1:0] PRIME_DONE = 2'h3;

endpackage : eii_pkg

// ==== logic/eii_noise_filter.sv ====
// One digital noise filter with edge detection for an interrupt input pin.
// Assumes pin is synchronous; sample_en marks counting periods; thr is at least one.
`timescale 1ns/1ns
module eii_noise_filter
  import eii_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       pin,
  input  wire logic       sample_en,
  input  wire logic [6:0] thr,
  output logic            filt,
  output logic            rise,
  output logic            fall
);

  logic       sync1_ff,  nxt_sync1;
  logic       sync2_ff,  nxt_sync2;
  logic [1:0] prime_ff,  nxt_prime;
  logic [6:0] cnt_ff,    nxt_cnt;
  logic       filt_ff,   nxt_filt;
  logic       rise_ff,   nxt_rise;
  logic       fall_ff,   nxt_fall;

  always_comb begin
    nxt_sync1 = pin;
    nxt_sync2 = sync1_ff;
    nxt_prime = prime_ff;
    nxt_cnt   = cnt_ff;
    nxt_filt  = filt_ff;
    nxt_rise  = 1'b0;
    nxt_fall  = 1'b0;
    if (prime_ff != PRIME_DONE) begin
      // Take the settled pin level after reset without reporting an edge
      nxt_prime = prime_ff + 2'h1;
      nxt_filt  = sync2_ff; // [R12]
      nxt_cnt   = 7'h00;
    end else if (sync2_ff == filt_ff) begin
      nxt_cnt = 7'h00; // [R19]
    end else if (sample_en) begin
      if (cnt_ff + 7'h01 >= thr) begin
        nxt_filt = sync2_ff; // [R1] [R19]
        nxt_cnt  = 7'h00;
        nxt_rise = sync2_ff;
        nxt_fall = ~sync2_ff;
      end else begin
        nxt_cnt = cnt_ff + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prime_ff <= 2'h0;
      cnt_ff   <= 7'h00;
      filt_ff  <= 1'b0;
      rise_ff  <= 1'b0;
      fall_ff  <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prime_ff <= nxt_prime;
      cnt_ff   <= nxt_cnt;
      filt_ff  <= nxt_filt;
      rise_ff  <= nxt_rise;
      fall_ff  <= nxt_fall;
    end
  end

  assign filt = filt_ff;
  assign rise = rise_ff;
  assign fall = fall_ff;

endmodule : eii_noise_filter

// ==== logic/eii_ext_irq_unit.sv ====
// External interrupt input unit: six filtered inputs, trigger logic, request latches.
// Assumes Avalon-MM master on clk; pins, slow tick and accept pulses synchronous to clk.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
module eii_ext_irq_unit
  import eii_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        shared_port_bit,
  input  wire logic        ext_irq_in1,
  input  wire logic        ext_irq_in2,
  input  wire logic        ext_irq_in3,
  input  wire logic        ext_irq_in4,
  input  wire logic        ext_irq_in5,
  input  wire logic        slow_mode,
  input  wire logic        low_clk_tick,
  input  wire logic        clock_divider_sel,
  input  wire logic [5:0]  irq_accept,
  output logic             irq0_pin_function_sel,
  output logic      [5:0]  irq_pending,
  output logic             irq_request
);

  eii_ctrl_s   ctrl_ff,   nxt_ctrl;
  eii_en_s     en_ff,     nxt_en;
  logic        ack_ff,    nxt_ack;
  logic [31:0] rdata_ff,  nxt_rdata;
  logic [5:0]  latch_ff,  nxt_latch;
  logic        armed4_ff, nxt_armed4;
  logic        phase_ff,  nxt_phase;

  logic        bus_req;
  logic        bus_take;
  logic [5:0]  sw_clr;
  logic [5:0]  pins;
  logic [5:0]  filt;
  logic [5:0]  rise;
  logic [5:0]  fall;
  logic [5:0]  trig;
  logic [5:0]  gate;
  logic        sample_en;
  logic [6:0]  thr [N_IRQ];

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // Bus slave: one wait cycle, answer in the second cycle of the request
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_ff;
  assign bus_take        = bus_req & ack_ff;
  assign sw_clr          = (bus_take && avs_write && avs_address == ADDR_LATCH &&
                            avs_byteenable[0]) ? avs_writedata[5:0] : 6'h00;

  always_comb begin
    logic [31:0] merged;
    merged    = 32'h0000_0000;
    nxt_ack   = bus_req & ~ack_ff;
    nxt_rdata = rdata_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_en    = en_ff;
    if (avs_read && !ack_ff) begin
      unique case (avs_address)
        ADDR_CTRL:  nxt_rdata = {24'h00_0000, 8'(ctrl_ff) & 8'hfe}; // [R18]
        ADDR_EN:    nxt_rdata = {21'h00_0000, 11'(en_ff)};
        ADDR_LATCH: nxt_rdata = {26'h000_0000, latch_ff};
        default:    nxt_rdata = 32'h0000_0000;
      endcase
    end
    if (bus_take && avs_write) begin
      unique case (avs_address)
        ADDR_CTRL: begin
          merged        = be_merge({24'h00_0000, 8'(ctrl_ff)}, avs_writedata, avs_byteenable);
          nxt_ctrl      = eii_ctrl_s'(merged[7:0]); // [R18]
          nxt_ctrl.rsvd = 1'b0;
        end
        ADDR_EN: begin
          merged = be_merge({21'h00_0000, 11'(en_ff)}, avs_writedata, avs_byteenable);
          nxt_en = eii_en_s'(merged[10:0]);
        end
        default: begin
          merged = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff  <= eii_ctrl_s'(CTRL_RST); // [R2] [R18]
      en_ff    <= eii_en_s'(EN_RST);
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
      ctrl_ff  <= nxt_ctrl;
      en_ff    <= nxt_en;
    end
  end

  assign avs_readdata          = rdata_ff;
  assign irq0_pin_function_sel = ctrl_ff.pin_func; // [R3]

  // Filter sampling rate and thresholds; window changes apply at once
  assign sample_en = slow_mode ? low_clk_tick : (~clock_divider_sel | phase_ff); // [R9]

  always_comb begin
    thr[0] = slow_mode ? CNT_SLOW : CNT_INT05; // [R5] [R9]
    thr[5] = thr[0];
    thr[1] = slow_mode ? CNT_SLOW
           : (ctrl_ff.noise_win ? CNT_EXT_IRQ_IN1_S : CNT_EXT_IRQ_IN1_L); // [R6] [R7] [R15]
    thr[2] = slow_mode ? CNT_SLOW : CNT_INT234; // [R8]
    thr[3] = thr[2];
    thr[4] = thr[2];
  end

  assign pins = {ext_irq_in5, ext_irq_in4, ext_irq_in3, ext_irq_in2, ext_irq_in1,
                 shared_port_bit};

  for (genvar i = 0; i < N_IRQ; i++) begin : g_filt
    eii_noise_filter u_filt (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin       (pins[i]),
      .sample_en (sample_en),
      .thr       (thr[i]),
      .filt      (filt[i]),
      .rise      (rise[i]),
      .fall      (fall[i])
    ); // [R1]
  end

  // Trigger selection per input
  always_comb begin
    trig[0] = fall[0] & ctrl_ff.pin_func; // [R4] [R5]
    trig[1] = ctrl_ff.es1 ? fall[1] : rise[1]; // [R10]
    trig[2] = ctrl_ff.es2 ? fall[2] : rise[2]; // [R10]
    trig[3] = ctrl_ff.es3 ? fall[3] : rise[3]; // [R10]
    unique case (ctrl_ff.trig4)
      TRIG_RISE:  trig[4] = rise[4]; // [R11]
      TRIG_FALL:  trig[4] = fall[4];
      TRIG_BOTH:  trig[4] = rise[4] | fall[4];
      TRIG_LEVEL: trig[4] = filt[4] & (armed4_ff | rise[4]); // [R12]
    endcase
    trig[5] = fall[5]; // [R5]
  end

  // Latches: a new trigger wins over a clear in the same cycle
  always_comb begin
    nxt_latch  = (latch_ff & ~(irq_accept | sw_clr)) | trig; // [R14] [R20]
    nxt_armed4 = armed4_ff | rise[4]; // [R12]
    nxt_phase  = ~phase_ff;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_ff  <= LATCH_RST;
      armed4_ff <= 1'b0;
      phase_ff  <= 1'b0;
    end else begin
      latch_ff  <= nxt_latch;
      armed4_ff <= nxt_armed4;
      phase_ff  <= nxt_phase;
    end
  end

  // Request to the CPU side needs master and own enables, plus an extra enable for every input except input 1
  assign gate        = {en_ff.lvl, 1'b1, ctrl_ff.pin_func}; // [R13]
  assign irq_request = en_ff.master & |(latch_ff & en_ff.ind & gate); // [R13] [R17]
  assign irq_pending = latch_ff;

endmodule : eii_ext_irq_unit

// ==== testbench/eii_pin_source.sv ====
// Model of the signal sources on the six interrupt pins.
// Assumes the bench sets lvl by non-blocking assignment at a rising clk edge.
`timescale 1ns/1ns
module eii_pin_source (
  input  wire logic       clk,
  input  wire logic [5:0] lvl,
  output logic      [5:0] pins = 6'h21
);
  // Sources only drive, the shared pin stays a device input
  always @(posedge clk) begin
    pins <= lvl;
  end
endmodule : eii_pin_source

// ==== testbench/eii_irq_checker.sv ====
// Port assertions for the external interrupt unit.
// Assumes one clock domain; bound to every instance of the unit.
`timescale 1ns/1ns
module eii_irq_checker
  import eii_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        ext_irq_in2,
  input wire logic        ext_irq_in5,
  input wire logic        slow_mode,
  input wire logic        clock_divider_sel,
  input wire logic        irq0_pin_function_sel,
  input wire logic [5:0]  irq_pending,
  input wire logic        irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic fast;
  assign fast = !slow_mode && !clock_divider_sel;
  sequence req_new;
    $rose(avs_read || avs_write);
  endsequence
  sequence wr_acc(logic [7:0] a);
    avs_write && !avs_waitrequest && avs_address == a && avs_byteenable[0];
  endsequence
  sequence rd_acc(logic [7:0] a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence
  bus_answer_a: assert property (req_new |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer late");
  ctrl_read_a: assert property (rd_acc(ADDR_CTRL) |-> avs_readdata[0] == 1'b0)
    else $error("control bit 0 reads one");
  unmapped_read_a: assert property (rd_acc(8'h40) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  pin_func_a: assert property (wr_acc(ADDR_CTRL) |=>
    irq0_pin_function_sel == $past(avs_writedata[6])) else $error("pin function wrong");
  ext_irq_in0_block_a: assert property (!irq0_pin_function_sel && !irq_pending[0]
    |=> !irq_pending[0]) else $error("port pin set latch 0");
  in5_fall_a: assert property (fast && $rose(irq_pending[5])
    |-> $past(ext_irq_in5, 5) == 1'b0) else $error("latch 5 without low input");
  in2_filter_a: assert property (fast && $rose(irq_pending[2])
    |-> $past(ext_irq_in2, 5) == $past(ext_irq_in2, 10)) else $error("latch 2 too soon");
  req_latch_a: assert property (irq_request |-> irq_pending != 6'h00)
    else $error("request without latch");
  req_mask_a: assert property (wr_acc(ADDR_EN) ##0 !avs_writedata[0] |=> !irq_request)
    else $error("request while masked");
  reset_quiet_a: assert property ($rose(rst_b) |-> irq_pending == 6'h00 &&
    !irq_request && !irq0_pin_function_sel) else $error("state after reset");
endmodule : eii_irq_checker
bind eii_ext_irq_unit eii_irq_checker eii_irq_checker_inst (.*);

// ==== testbench/eii_ext_irq_unit_bench.sv ====
// Self-checking bench for the external interrupt input unit.
// Assumes the unit, its checker and the pin source model are compiled first.
`timescale 1ns/1ns
module eii_ext_irq_unit_bench
  import eii_pkg::*;
;
  logic        clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        slow_mode = 1'b0, low_clk_tick = 1'b0, clock_divider_sel = 1'b0;
  logic        avs_waitrequest, irq0_pin_function_sel, irq_request;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'hf, be = 4'hf;
  logic [5:0]  irq_accept = 6'h00, lvl = 6'h21, irq_pending, pins;
  int          num_errors = 0, compares = 0, tk = 0;
  always #5 clk = ~clk;
  // One slow tick every fourth cycle
  always @(posedge clk) begin
    tk <= tk + 1;
    low_clk_tick <= (tk % 4 == 3);
  end
  eii_ext_irq_unit eii_ext_irq_unit_inst (.*, .shared_port_bit(pins[0]),
    .ext_irq_in1(pins[1]), .ext_irq_in2(pins[2]), .ext_irq_in3(pins[3]),
    .ext_irq_in4(pins[4]), .ext_irq_in5(pins[5]));
  eii_pin_source eii_pin_source_inst (.clk(clk), .lvl(lvl), .pins(pins));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    // Sampled at the rising edge, before this edge's updates land
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) num_errors++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask : rd
  task automatic clr();
    bus(1'b1, ADDR_LATCH, 32'h3f);
  endtask : clr
  task automatic step(input int i, input logic v, input int w);
    @(posedge clk);
    lvl[i] <= v;
    repeat (w - 1) @(posedge clk);
    @(negedge clk);
  endtask : step
  task automatic finish_test();
    $display("Compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // Run takes about 1100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_CTRL, "ctrl", 32'h0);
    rd(ADDR_EN, "en", 32'h0);
    rd(8'h40, "unmapped", 32'h0);
    chk("pin_func", irq0_pin_function_sel, 1'b0);
    be = 4'h0;
    bus(1'b1, ADDR_CTRL, 32'hff);
    be = 4'hf;
    rd(ADDR_CTRL, "ctrl_be", 32'h0);
    bus(1'b1, ADDR_CTRL, 32'hff);
    rd(ADDR_CTRL, "ctrl_rw", 32'hfe);
    bus(1'b1, ADDR_CTRL, 32'h0);
    clr();
    $display("Registers done");
    step(0, 1'b0, 12);
    chk("pend0_port", irq_pending[0], 1'b0);
    step(0, 1'b1, 12);
    bus(1'b1, ADDR_CTRL, 32'h40);
    step(0, 1'b0, 12);
    chk("pend0", irq_pending[0], 1'b1);
    bus(1'b1, ADDR_EN, 32'h3);
    chk("req0", irq_request, 1'b1);
    bus(1'b1, ADDR_EN, 32'h2);
    chk("req0_off", irq_request, 1'b0);
    clr();
    chk("clr0", irq_pending[0], 1'b0);
    $display("Input 0 done");
    step(5, 1'b0, 1);
    step(5, 1'b1, 12);
    chk("pend5_glitch", irq_pending[5], 1'b0);
    step(5, 1'b0, 7);
    step(5, 1'b1, 12);
    chk("pend5", irq_pending[5], 1'b1);
    @(posedge clk);
    irq_accept <= 6'h20;
    @(posedge clk);
    irq_accept <= 6'h00;
    @(negedge clk);
    chk("acc5", irq_pending[5], 1'b0);
    // Halved count rate: a two-cycle pulse no longer passes
    @(posedge clk);
    clock_divider_sel <= 1'b1;
    step(5, 1'b0, 2);
    step(5, 1'b1, 12);
    chk("div_glitch", irq_pending[5], 1'b0);
    step(5, 1'b0, 7);
    step(5, 1'b1, 12);
    chk("div_pulse", irq_pending[5], 1'b1);
    @(posedge clk);
    clock_divider_sel <= 1'b0;
    clr();
    chk("div_clr", irq_pending[5], 1'b0);
    @(posedge clk);
    slow_mode <= 1'b1;
    step(5, 1'b0, 3);
    step(5, 1'b1, 40);
    chk("slow_glitch", irq_pending[5], 1'b0);
    step(5, 1'b0, 14);
    step(5, 1'b1, 40);
    chk("slow_pulse", irq_pending[5], 1'b1);
    @(posedge clk);
    slow_mode <= 1'b0;
    $display("Input 5 done");
    for (int es = 0; es < 2; es++) begin
      bus(1'b1, ADDR_CTRL, es ? 32'hce : 32'h80);
      clr();
      for (int i = 1; i < 4; i++) begin
        step(i, 1'b1, 24);
        chk("edge_rise", irq_pending[i], !es);
        clr();
        step(i, 1'b0, 24);
        chk("edge_fall", irq_pending[i], es);
        clr();
      end
    end
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, ADDR_CTRL, 32'(m << 4));
      clr();
      step(4, 1'b1, 16);
      chk("in4_rise", irq_pending[4], m != 1);
      clr();
      step(4, 1'b0, 16);
      chk("in4_fall", irq_pending[4], m != 0);
      clr();
      chk("in4_low", irq_pending[4], 1'b0);
    end
    $display("Trigger modes done");
    bus(1'b1, ADDR_CTRL, 32'h0);
    clr();
    step(1, 1'b1, 40);
    step(1, 1'b0, 80);
    chk("win_long", irq_pending[1], 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h80);
    clr();
    step(1, 1'b1, 40);
    step(1, 1'b0, 80);
    chk("win_short", irq_pending[1], 1'b1);
    $display("Window done");
    @(posedge clk);
    rst_b <= 1'b0;
    lvl[4] <= 1'b1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h30);
    step(4, 1'b1, 20);
    chk("lvl_after_rst", irq_pending[4], 1'b0);
    step(4, 1'b0, 16);
    step(4, 1'b1, 16);
    chk("lvl_armed", irq_pending[4], 1'b1);
    $display("Level rearm done");
    finish_test();
  end
endmodule : eii_ext_irq_unit_bench
